/* File: hw/ctr_pkg.sv */
// shared constants for the authenticated counter engine and its host
package ctr_pkg;
  // link opcodes and sub-commands
  localparam logic [7:0] OP_COUNTER = 8'h9b;
  localparam logic [7:0] OP_STATUS = 8'h96;
  localparam logic [7:0] SUB_KEY = 8'h01;
  localparam logic [7:0] SUB_INC = 8'h02;
  localparam logic [7:0] SUB_REQ = 8'h03;
  localparam logic [7:0] RSV_BYTE = 8'h00;
  // payload bit counts after the opcode byte
  localparam logic [8:0] LEN_SHORT = 9'h138;  // 312 bits
  localparam logic [8:0] LEN_REQ = 9'h178;    // 376 bits
  localparam logic [8:0] LEN_STS = 9'h008;    // status byte only
  localparam logic [8:0] LEN_DATA = 9'h188;   // status plus response
  localparam int RESP_W = 384;
  // result status values and bit positions
  localparam logic [7:0] ST_RESET = 8'h00;
  localparam logic [7:0] ST_OK = 8'h80;
  localparam logic [7:0] ST_BUSY = 8'h01;
  localparam int B_UNINIT = 1;
  localparam int B_AUTH = 2;
  localparam int B_KEY = 3;
  localparam int B_MISMATCH = 4;
  localparam int B_FATAL = 5;
  localparam int B_OK = 7;
  // host controller register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INDEX = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_TAG0 = 8'h0c;
  localparam logic [7:0] OFF_TAG1 = 8'h10;
  localparam logic [7:0] OFF_TAG2 = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_RCOUNT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_ST = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
  // host operation codes in the control register
  localparam logic [1:0] HOP_SIGNED = 2'h0;
  localparam logic [1:0] HOP_STATUS = 2'h1;
  localparam logic [1:0] HOP_DATA = 2'h2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_BADRESP = 1;
endpackage

/* File: hw/ctr_link_if.sv */
// serial link between host controller and counter engine
`timescale 1ns/1ps
`default_nettype none
interface ctr_link_if;
  logic sel;  // frame select, high during a frame
  logic si;   // host to device bit, msb first
  logic so;   // device to host bit
  modport device (input sel, input si, output so);
  modport host (output sel, output si, input so);
endinterface
`default_nettype wire

/* File: hw/keyed_digest.sv */
// keyed 256-bit digest of a 128-bit message
`timescale 1ns/1ps
`default_nettype none
module keyed_digest (
  input wire logic [255:0] key,     // secret key
  input wire logic [127:0] msg,     // message, left justified
  output logic [255:0] digest       // keyed result
);
  logic [31:0] s [8];
  logic [31:0] t;

  // four mixing rounds over eight lanes; purely combinational so that
  // a result is ready in the same cycle its inputs are
  always_comb begin
    t = 32'h0;
    for (int i = 0; i < 8; i++) s[i] = key[32*i +: 32];
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 8; i++) begin
        t = s[i] ^ msg[32*((i+r)%4) +: 32] ^ 32'(r * 8 + i);
        s[i] = {t[24:0], t[31:25]} + s[(i+1)%8];
      end
    end
    for (int i = 0; i < 8; i++) digest[32*i +: 32] = s[i];
  end
endmodule
`default_nettype wire

/* File: hw/counter_engine_dev.sv */
// authenticated monotonic counter engine, device end of the link
//
// Notes on behaviour
// - four volatile 256-bit session keys, one each
// - host refreshes session keys after each power cycle
// - key update stores digest of root over seed
// - key update carries signature the device checks
// - successful increment raises counter by exactly one
// - increment carries last read counter, compared
// - counter value mismatch sets status bit 4
// - missing session key or counter sets bit 3
// - bad signature, index or length sets bit 2
// - uninitialized counter sets status bit 1
// - 96h returns status; bit 0 busy, 80h success
// - request tag signature checked before responding
// - host reads tag, counter, signature after busy
// - response signed over tag then counter value
// - sub-commands 04h and above set bit 2
// - status zero after reset; bit 5 fatal
// - status held until new counter opcode byte; here fatal_error sets bit 5 and clears bit 7 at any time
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module counter_engine_dev #(
  parameter int NUM_CTR = 4
) (
  input wire logic clock,                        // system clock
  input wire logic rst,                          // sync reset, high
  ctr_link_if.device link,                       // serial link
  input wire logic [4*256-1:0] root_secret,      // per-counter root keys
  input wire logic [3:0] counter_ready,          // counter initialized
  input wire logic fatal_error,                  // internal fatal fault
  output logic [7:0] result_status,              // current status byte
  output logic [4*32-1:0] counter_values         // all counter values
);
  if (NUM_CTR < 1 || NUM_CTR > 4) begin : g_chk
    $error("NUM_CTR must be 1 to 4");
  end

  typedef enum logic [1:0] {
    S_OPC = 2'h0,
    S_PAY = 2'h1,
    S_OUT = 2'h3,
    S_SKIP = 2'h2
  } dev_state_t;

  dev_state_t state_q;
  logic [8:0] cnt_q;
  logic [375:0] buf_q;
  logic [7:0] sub_q;
  logic [7:0] idx_q;
  logic [7:0] status_q;
  logic [255:0] key_q [4];
  logic [3:0] key_ok_q;
  logic [31:0] ctr_q [4];
  localparam int RESP_W_L = ctr_pkg::RESP_W;
  logic [RESP_W_L-1:0] resp_q;
  logic resp_v_q;
  logic [390:0] out_q;
  logic so_q;

  //////////////////////////////////////////////////////////////////////
  // frame decode
  logic [7:0] opcode;
  logic opc_done;
  logic finish;
  logic [1:0] ks;
  logic is_req;
  logic known;
  logic len_ok;
  logic range_ok;
  logic [7:0] r_res;
  logic [31:0] data32;
  logic [95:0] tag;
  logic [255:0] sig;
  logic [255:0] root_k;
  logic [255:0] sig_key;
  logic [127:0] msg;
  logic [255:0] sig_calc;
  logic [255:0] new_key;
  logic [255:0] rsp_sig;
  logic auth_err;
  logic uninit;
  logic key_err;
  logic mismatch;
  logic ok;
  logic [7:0] new_status;

  assign opcode = {buf_q[6:0], link.si};
  assign opc_done = state_q == S_OPC && link.sel && cnt_q == 9'h007;
  assign finish = state_q == S_PAY && !link.sel;
  assign range_ok = idx_q < 8'(NUM_CTR);
  assign ks = range_ok ? idx_q[1:0] : 2'h0;
  assign is_req = sub_q == ctr_pkg::SUB_REQ;
  assign known = sub_q == ctr_pkg::SUB_KEY || sub_q == ctr_pkg::SUB_INC
                 || is_req;
  assign len_ok = cnt_q == (is_req ? ctr_pkg::LEN_REQ
                                   : ctr_pkg::LEN_SHORT);
  // field positions depend on the payload layout of the sub-command
  assign r_res = is_req ? buf_q[359:352] : buf_q[295:288];
  assign data32 = buf_q[287:256];
  assign tag = buf_q[351:256];
  assign sig = buf_q[255:0];
  assign root_k = root_secret[256*ks +: 256];
  // key update is signed with the root so it works after power-up
  assign sig_key = sub_q == ctr_pkg::SUB_KEY ? root_k : key_q[ks];
  assign msg = is_req ? {ctr_pkg::OP_COUNTER, sub_q, idx_q, r_res, tag}
             : {ctr_pkg::OP_COUNTER, sub_q, idx_q, r_res, data32, 64'h0};

  keyed_digest u_sig (
    .key(sig_key),
    .msg(msg),
    .digest(sig_calc)
  );
  keyed_digest u_key (
    .key(root_k),
    .msg({data32, 96'h0}),
    .digest(new_key)
  );
  keyed_digest u_rsp (
    .key(key_q[ks]),
    .msg({tag, ctr_q[ks]}),
    .digest(rsp_sig)
  );

  //////////////////////////////////////////////////////////////////////
  // outcome of a completed counter frame
  always_comb begin
    auth_err = !known || !len_ok || !range_ok || sig_calc != sig;
    uninit = known && range_ok && !counter_ready[ks];
    key_err = (sub_q == ctr_pkg::SUB_INC || is_req) && range_ok
              && (!key_ok_q[ks] || !counter_ready[ks]);
    mismatch = sub_q == ctr_pkg::SUB_INC && range_ok && len_ok
               && data32 != ctr_q[ks];
    ok = !(auth_err || uninit || key_err || mismatch || fatal_error);
    new_status = 8'h00;
    if (ok) begin
      new_status = ctr_pkg::ST_OK;
    end else begin
      new_status[ctr_pkg::B_AUTH] = auth_err;
      new_status[ctr_pkg::B_UNINIT] = uninit;
      new_status[ctr_pkg::B_KEY] = key_err;
      new_status[ctr_pkg::B_MISMATCH] = mismatch;
      new_status[ctr_pkg::B_FATAL] = fatal_error;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // link sequencing
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= S_OPC;
      cnt_q <= 9'h000;
    end else begin
      case (state_q)
        S_OPC: begin
          if (!link.sel) begin
            cnt_q <= 9'h000;
          end else if (opc_done) begin
            cnt_q <= 9'h000;
            if (opcode == ctr_pkg::OP_COUNTER) begin
              state_q <= S_PAY;
            end else if (opcode == ctr_pkg::OP_STATUS) begin
              state_q <= S_OUT;
            end else begin
              state_q <= S_SKIP;
            end
          end else begin
            cnt_q <= cnt_q + 9'h001;
          end
        end
        S_PAY: begin
          if (!link.sel) begin
            state_q <= S_OPC;
            cnt_q <= 9'h000;
          end else if (cnt_q != 9'h1ff) begin
            cnt_q <= cnt_q + 9'h001;  // saturates on long frames
          end
        end
        default: begin
          if (!link.sel) begin
            state_q <= S_OPC;
          end
        end
      endcase
    end
  end

  // incoming shift register and header bytes
  always_ff @(posedge clock) begin
    if (rst) begin
      buf_q <= '0;
      sub_q <= 8'h00;
      idx_q <= 8'h00;
    end else if (link.sel && (state_q == S_OPC || state_q == S_PAY)) begin
      buf_q <= {buf_q[374:0], link.si};
      if (state_q == S_PAY && cnt_q == 9'h007) begin
        sub_q <= {buf_q[6:0], link.si};
      end
      if (state_q == S_PAY && cnt_q == 9'h00f) begin
        idx_q <= {buf_q[6:0], link.si};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // result status: held until a counter opcode byte is complete, but fatal_error sets bit 5 and clears bit 7 at any time
  always_ff @(posedge clock) begin
    if (rst) begin
      status_q <= ctr_pkg::ST_RESET;
    end else if (opc_done && opcode == ctr_pkg::OP_COUNTER) begin
      status_q <= ctr_pkg::ST_BUSY;
      status_q[ctr_pkg::B_FATAL] <= fatal_error;
    end else if (finish) begin
      status_q <= new_status;
    end else if (fatal_error) begin
      status_q[ctr_pkg::B_FATAL] <= 1'b1;
      status_q[ctr_pkg::B_OK] <= 1'b0;
    end
  end

  // session keys are volatile: lost on every reset
  always_ff @(posedge clock) begin
    if (rst) begin
      key_ok_q <= 4'h0;
      for (int i = 0; i < 4; i++) key_q[i] <= '0;
    end else if (finish && ok && sub_q == ctr_pkg::SUB_KEY) begin
      key_q[ks] <= new_key;
      key_ok_q[ks] <= 1'b1;
    end
  end

  // counters; kept in flops here, so reset restarts them at zero
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) ctr_q[i] <= 32'h0;
    end else if (finish && ok && sub_q == ctr_pkg::SUB_INC) begin
      ctr_q[ks] <= ctr_q[ks] + 32'h1;
    end
  end

  // signed response to a counter request
  always_ff @(posedge clock) begin
    if (rst) begin
      resp_q <= '0;
      resp_v_q <= 1'b0;
    end else if (opc_done && opcode == ctr_pkg::OP_COUNTER) begin
      resp_v_q <= 1'b0;
    end else if (finish && ok && is_req) begin
      resp_q <= {tag, ctr_q[ks], rsp_sig};
      resp_v_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // status/data read: status byte, then response once not busy
  always_ff @(posedge clock) begin
    if (rst) begin
      out_q <= '0;
      so_q <= 1'b0;
    end else if (opc_done && opcode == ctr_pkg::OP_STATUS) begin
      so_q <= status_q[7];
      out_q <= {status_q[6:0],
                (resp_v_q && !status_q[0]) ? resp_q : {RESP_W_L{1'b0}}};
    end else if (state_q == S_OUT && link.sel) begin
      so_q <= out_q[390];
      out_q <= {out_q[389:0], 1'b0};
    end else begin
      so_q <= 1'b0;
    end
  end

  assign link.so = so_q;
  assign result_status = status_q;
  for (genvar g = 0; g < 4; g++) begin : g_out
    assign counter_values[32*g +: 32] = ctr_q[g];
  end
endmodule
`default_nettype wire

/* File: hw/counter_engine_host.sv */
// host controller that drives signed counter frames over the link
`timescale 1ns/1ps
`default_nettype none
module counter_engine_host #(
  parameter int NUM_CTR = 4
) (
  input wire logic clock,                    // system clock
  input wire logic rst,                      // sync reset, high
  ctr_link_if.host link,                     // serial link
  input wire logic [4*256-1:0] root_secret,  // shared root keys
  input wire logic [7:0] addr,               // register byte address
  input wire logic [31:0] wdata,             // write data
  input wire logic wr,                       // write strobe
  input wire logic rd,                       // read strobe
  output logic [31:0] rdata,                 // read data, next cycle
  output logic irq                           // level interrupt
);
  if (NUM_CTR < 1 || NUM_CTR > 4) begin : g_chk
    $error("NUM_CTR must be 1 to 4");
  end

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_TX = 2'h1,
    H_RX = 2'h3,
    H_GAP = 2'h2
  } host_state_t;

  host_state_t state_q;
  logic [8:0] cnt_q;
  logic [8:0] tx_n_q;
  logic [8:0] rx_n_q;
  logic [383:0] tx_q;
  logic [391:0] rx_q;
  logic sel_q;
  logic si_q;
  logic [7:0] idx_q;
  logic [31:0] data_q;
  logic [95:0] tag_q;
  logic [31:0] seed_q [4];
  logic [7:0] status_q;
  logic [31:0] rcount_q;
  logic resp_ok_q;
  logic [1:0] irq_st_q;
  logic [1:0] irq_mask_q;

  //////////////////////////////////////////////////////////////////////
  // frame construction and signatures
  logic [1:0] op;
  logic [7:0] sub;
  logic start;
  logic [1:0] k;
  logic [255:0] root_k;
  logic [255:0] sess;
  logic [255:0] sig;
  logic [255:0] rsp_chk;
  logic [127:0] msg;
  logic [383:0] frame;
  logic [1:0] ev;

  assign op = wdata[1:0];
  assign sub = wdata[15:8];
  assign start = wr && addr == ctr_pkg::OFF_CTRL && state_q == H_IDLE
                 && op != 2'h3;
  assign k = idx_q[1:0];
  assign root_k = root_secret[256*k +: 256];
  assign msg = sub == ctr_pkg::SUB_REQ
             ? {ctr_pkg::OP_COUNTER, sub, idx_q, ctr_pkg::RSV_BYTE, tag_q}
             : {ctr_pkg::OP_COUNTER, sub, idx_q, ctr_pkg::RSV_BYTE,
                data_q, 64'h0};

  // host keeps seeds, not keys, and rebuilds the session key on demand
  keyed_digest u_sess (
    .key(root_k),
    .msg({seed_q[k], 96'h0}),
    .digest(sess)
  );
  keyed_digest u_sig (
    .key(sub == ctr_pkg::SUB_KEY ? root_k : sess),
    .msg(msg),
    .digest(sig)
  );
  keyed_digest u_chk (
    .key(sess),
    .msg(rx_q[383:256]),
    .digest(rsp_chk)
  );

  always_comb begin
    frame = '0;
    if (op != ctr_pkg::HOP_SIGNED) begin
      frame[383:376] = ctr_pkg::OP_STATUS;
    end else if (sub == ctr_pkg::SUB_REQ) begin
      frame = {msg[127:120], msg[119:0], sig};
    end else begin
      frame = {msg[127:64], sig, 64'h0};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // link sequencer; one idle cycle at least separates frames
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= H_IDLE;
      cnt_q <= 9'h000;
      tx_n_q <= 9'h000;
      rx_n_q <= 9'h000;
      tx_q <= '0;
      rx_q <= '0;
      sel_q <= 1'b0;
      si_q <= 1'b0;
    end else begin
      case (state_q)
        H_IDLE: begin
          if (start) begin
            state_q <= H_TX;
            sel_q <= 1'b1;
            si_q <= frame[383];
            tx_q <= {frame[382:0], 1'b0};
            cnt_q <= 9'h001;
            tx_n_q <= op != ctr_pkg::HOP_SIGNED ? ctr_pkg::LEN_STS
                    : sub == ctr_pkg::SUB_REQ ? ctr_pkg::LEN_REQ + 9'h008
                    : ctr_pkg::LEN_SHORT + 9'h008;
            rx_n_q <= op == ctr_pkg::HOP_DATA ? ctr_pkg::LEN_DATA
                    : op == ctr_pkg::HOP_STATUS ? ctr_pkg::LEN_STS : 9'h000;
          end
        end
        H_TX: begin
          if (cnt_q == tx_n_q) begin
            cnt_q <= 9'h000;
            si_q <= 1'b0;
            if (rx_n_q != 9'h000) begin
              state_q <= H_RX;
            end else begin
              state_q <= H_GAP;
              sel_q <= 1'b0;
            end
          end else begin
            si_q <= tx_q[383];
            tx_q <= {tx_q[382:0], 1'b0};
            cnt_q <= cnt_q + 9'h001;
          end
        end
        H_RX: begin
          rx_q <= {rx_q[390:0], link.so};
          cnt_q <= cnt_q + 9'h001;
          if (cnt_q == rx_n_q - 9'h001) begin
            state_q <= H_GAP;
            sel_q <= 1'b0;
          end
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  // results are taken in the gap cycle, after the last bit arrived
  always_ff @(posedge clock) begin
    if (rst) begin
      status_q <= 8'h00;
      rcount_q <= 32'h0;
      resp_ok_q <= 1'b0;
    end else if (state_q == H_GAP && rx_n_q == ctr_pkg::LEN_STS) begin
      status_q <= rx_q[7:0];
    end else if (state_q == H_GAP && rx_n_q == ctr_pkg::LEN_DATA) begin
      status_q <= rx_q[391:384];
      rcount_q <= rx_q[287:256];
      resp_ok_q <= rsp_chk == rx_q[255:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clock) begin
    if (rst) begin
      idx_q <= 8'h00;
      data_q <= 32'h0;
      tag_q <= '0;
      irq_mask_q <= 2'h0;
      for (int i = 0; i < 4; i++) seed_q[i] <= 32'h0;
    end else if (wr) begin
      case (addr)
        ctr_pkg::OFF_INDEX: idx_q <= wdata[7:0];
        ctr_pkg::OFF_DATA: data_q <= wdata;
        ctr_pkg::OFF_TAG0: tag_q[31:0] <= wdata;
        ctr_pkg::OFF_TAG1: tag_q[63:32] <= wdata;
        ctr_pkg::OFF_TAG2: tag_q[95:64] <= wdata;
        ctr_pkg::OFF_IRQ_MASK: irq_mask_q <= wdata[1:0];
        ctr_pkg::OFF_CTRL: begin
          if (start && op == ctr_pkg::HOP_SIGNED && sub == ctr_pkg::SUB_KEY
              && idx_q < 8'(NUM_CTR)) begin
            seed_q[k] <= data_q;
          end
        end
        default: begin
        end
      endcase
    end
  end

  localparam int IRQ_DONE_L = ctr_pkg::IRQ_DONE;
  localparam int IRQ_BAD_L = ctr_pkg::IRQ_BADRESP;
  // sticky events; a new event wins over a same-cycle clear
  assign ev[IRQ_DONE_L] = state_q == H_GAP;
  assign ev[IRQ_BAD_L] = state_q == H_GAP && rx_n_q == ctr_pkg::LEN_DATA
                         && rsp_chk != rx_q[255:0];
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_st_q <= 2'h0;
    end else begin
      irq_st_q <= (irq_st_q & ~((wr && addr == ctr_pkg::OFF_IRQ_ST)
                                ? wdata[1:0] : 2'h0)) | ev;
    end
  end
  assign irq = |(irq_st_q & irq_mask_q);

  // read data stands in the cycle after the strobe only
  always_ff @(posedge clock) begin
    if (rst || !rd) begin
      rdata <= 32'h0;
    end else begin
      case (addr)
        ctr_pkg::OFF_INDEX: rdata <= {24'h0, idx_q};
        ctr_pkg::OFF_DATA: rdata <= data_q;
        ctr_pkg::OFF_TAG0: rdata <= tag_q[31:0];
        ctr_pkg::OFF_TAG1: rdata <= tag_q[63:32];
        ctr_pkg::OFF_TAG2: rdata <= tag_q[95:64];
        ctr_pkg::OFF_STAT: rdata <= {22'h0, resp_ok_q,
                                     state_q != H_IDLE, status_q};
        ctr_pkg::OFF_RCOUNT: rdata <= rcount_q;
        ctr_pkg::OFF_IRQ_ST: rdata <= {30'h0, irq_st_q};
        ctr_pkg::OFF_IRQ_MASK: rdata <= {30'h0, irq_mask_q};
        default: rdata <= 32'h0;
      endcase
    end
  end

  assign link.sel = sel_q;
  assign link.si = si_q;
endmodule
`default_nettype wire

/* File: dv/auth_monotonic_counter_engine_chk.sv */
// link and status assertions for the counter engine pair
`timescale 1ns/1ps
`default_nettype none
module auth_monotonic_counter_engine_chk (
  input wire logic clock,  // system clock
  input wire logic rst,  // sync reset, high
  input wire logic sel,  // frame select
  input wire logic si,  // host to device bit
  input wire logic so,  // device to host bit
  input wire logic fatal_error,  // fault input
  input wire logic [7:0] result_status  // device status byte
);
  logic [3:0] cnt_q;
  logic [6:0] sh_q;
  logic [7:0] opc;
  // count opcode bits; saturate so long payloads cannot alias an opcode
  always_ff @(posedge clock) begin
    if (rst || !sel) cnt_q <= 4'h0;
    else if (cnt_q != 4'h8) cnt_q <= cnt_q + 4'h1;
  end
  // shift in frame bits, msb first
  always_ff @(posedge clock) begin
    if (sel) sh_q <= {sh_q[5:0], si};
  end
  assign opc = {sh_q, si};
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_op(logic [7:0] code);
    sel && cnt_q == 4'h7 && opc == code;
  endsequence
  sequence s_quiet;
    (!sel && !fatal_error)[*3];
  endsequence
  AST_RESET_ZERO: assert property (
    $fell(rst) |-> result_status == ctr_pkg::ST_RESET)
    else $error("status not zero after reset");
  AST_BUSY_ON_OPCODE: assert property (
    s_op(ctr_pkg::OP_COUNTER) ##0 !fatal_error
    |=> result_status == ctr_pkg::ST_BUSY)
    else $error("no busy after counter opcode");
  AST_STATUS_SHIFT: assert property (
    s_op(ctr_pkg::OP_STATUS)
    |=> so == result_status[7] ##7 so == result_status[0])
    else $error("status byte not shifted out");
  AST_HOLD_IDLE: assert property (
    s_quiet |-> $stable(result_status))
    else $error("status moved between frames");
  AST_HOLD_READ: assert property (
    s_op(ctr_pkg::OP_STATUS) |=> $stable(result_status)[*8])
    else $error("status moved during status read");
  AST_BUSY_NOT_OK: assert property (
    result_status[0] |-> !result_status[7])
    else $error("busy and success together");
  AST_OK_ALONE: assert property (
    result_status[7] |-> result_status[6:0] == 7'h00)
    else $error("success with other bits");
  AST_FATAL_SETS: assert property (
    fatal_error |-> ##[1:2] (result_status[5] && !result_status[7]))
    else $error("fatal bit not raised");
endmodule
`default_nettype wire

/* File: dv/auth_monotonic_counter_engine_test.sv */
// self-checking bench: host controller and engine joined by one link
`timescale 1ns/1ps
`default_nettype none
module auth_monotonic_counter_engine_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic fatal_error = 1'b0;
  logic irq;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] lfsr = 32'h3;
  logic [3:0] counter_ready = 4'h0;
  logic [1023:0] root_secret = '0;
  logic [7:0] result_status;
  logic [127:0] counter_values;
  logic [7:0] bsub [4] = '{8'h04, 8'hff, 8'h00, 8'h01};
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];
  int n_fail = 0;
  int cmp_count = 0;
  ctr_link_if link ();
  counter_engine_dev counter_engine_dev_inst (
    .clock(clock), .rst(rst), .link(link), .root_secret(root_secret),
    .counter_ready(counter_ready), .fatal_error(fatal_error),
    .result_status(result_status), .counter_values(counter_values));
  counter_engine_host counter_engine_host_inst (
    .clock(clock), .rst(rst), .link(link), .root_secret(root_secret),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  auth_monotonic_counter_engine_chk auth_monotonic_counter_engine_chk_inst (
    .clock(clock), .rst(rst), .sel(link.sel), .si(link.si), .so(link.so),
    .fatal_error(fatal_error), .result_status(result_status));
  //////////////////////////////////////////////////////////////////////////
  // free-running 50 MHz clock
  initial forever #10 clock = ~clock;
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, e, m);
    cmp_count++;
    if ((got & m) !== (e & m)) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e & m, got & m);
    end
  endtask
  // read data lands one cycle after the strobe; oldest note is compared
  always @(posedge clock) begin
    rd_q <= rd;
    if (rd_q) check("rdata", rdata, exp_q.pop_front(), msk_q.pop_front());
  end
  //////////////////////////////////////////////////////////////////////////
  // bus tasks wait an edge first so a strobe is never lowered and raised
  // in the same time step
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, m);
    @(posedge clock);
    exp_q.push_back(e);
    msk_q.push_back(m);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
  endtask
  task automatic wait_hi();
    int i = 0;
    while (irq !== 1'b1 && i < 2000) begin
      @(posedge clock);
      i++;
    end
    if (i == 2000) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic op(input logic [1:0] h, input logic [7:0] sub, idx,
                    input logic [31:0] d);
    wreg(ctr_pkg::OFF_INDEX, {24'h0, idx});
    wreg(ctr_pkg::OFF_DATA, d);
    wreg(ctr_pkg::OFF_CTRL, {16'h0, sub, 6'h0, h});
    wait_hi();
    wreg(ctr_pkg::OFF_IRQ_ST, 32'h1);
  endtask
  task automatic run(input logic [7:0] sub, idx, input logic [31:0] d, e, m);
    op(ctr_pkg::HOP_SIGNED, sub, idx, d);
    op(ctr_pkg::HOP_STATUS, 8'h00, 8'h00, 32'h0);
    rreg(ctr_pkg::OFF_STAT, e, m);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // main sequence: random root keys, then command scenarios
  initial begin
    for (int k = 0; k < 32; k++) begin
      lfsr = next_rand(lfsr);
      root_secret[32*k +: 32] = lfsr;
    end
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rreg(ctr_pkg::OFF_STAT, 32'h0, 32'h1ff);
    rreg(8'h30, 32'h0, 32'hffffffff);
    wreg(ctr_pkg::OFF_IRQ_MASK, 32'h1);
    lfsr = next_rand(lfsr);
    run(ctr_pkg::SUB_KEY, 8'h00, lfsr, 32'h02, 32'h1ff);
    counter_ready <= 4'hf;
    // no session key yet: the device cannot verify the signature either
    run(ctr_pkg::SUB_INC, 8'h02, 32'h0, 32'h0c, 32'h1ff);
    run(ctr_pkg::SUB_KEY, 8'h02, lfsr, 32'h80, 32'h1ff);
    run(ctr_pkg::SUB_INC, 8'h02, 32'h0, 32'h80, 32'h1ff);
    run(ctr_pkg::SUB_INC, 8'h02, 32'h0, 32'h10, 32'h1ff);
    run(ctr_pkg::SUB_INC, 8'h02, 32'h1, 32'h80, 32'h1ff);
    check("counter", counter_values[95:64], 32'h2, 32'hffffffff);
    for (int k = 0; k < 3; k++) begin
      lfsr = next_rand(lfsr);
      wreg(ctr_pkg::OFF_TAG0 + 8'(4 * k), lfsr);
    end
    op(ctr_pkg::HOP_SIGNED, ctr_pkg::SUB_REQ, 8'h02, 32'h0);
    // index must still name the counter whose response is checked
    op(ctr_pkg::HOP_DATA, 8'h00, 8'h02, 32'h0);
    rreg(ctr_pkg::OFF_STAT, 32'h280, 32'h3ff);
    rreg(ctr_pkg::OFF_RCOUNT, 32'h2, 32'hffffffff);
    // reserved subs, zero sub and an index past the last counter
    for (int k = 0; k < 4; k++) begin
      run(bsub[k], 8'(k / 3 * 4), 32'h0, 32'h4, 32'h4);
    end
    fatal_error <= 1'b1;
    op(ctr_pkg::HOP_STATUS, 8'h00, 8'h00, 32'h0);
    rreg(ctr_pkg::OFF_STAT, 32'h20, 32'ha1);
    fatal_error <= 1'b0;
    // raise done, then mask it, read it sticky and clear it
    wreg(ctr_pkg::OFF_CTRL, {30'h0, ctr_pkg::HOP_STATUS});
    wait_hi();
    wreg(ctr_pkg::OFF_IRQ_MASK, 32'h0);
    #1;
    check("irq", {31'h0, irq}, 32'h0, 32'h1);
    rreg(ctr_pkg::OFF_IRQ_ST, 32'h1, 32'h1);
    wreg(ctr_pkg::OFF_IRQ_ST, 32'h1);
    rreg(ctr_pkg::OFF_IRQ_ST, 32'h0, 32'h1);
    repeat (2) @(posedge clock);
    close_out();
  end
endmodule
`default_nettype wire
